/* File: ram_block_pkg.sv */
// shared constants and carrier types for the embedded ram block
package ram_block_pkg;
  localparam int TOTAL_BITS  = 2048;
  localparam int MAX_ADDR_W  = 11;
  localparam int MAX_DATA_W  = 8;
  localparam logic [7:0] RESET_DATA = 8'h00;
  localparam logic [10:0] RESET_ADDR = 11'h000;

  // shape select: depth by width
  typedef enum logic [1:0] {
    SHAPE_256X8  = 2'h0,
    SHAPE_512X4  = 2'h1,
    SHAPE_1KX2   = 2'h2,
    SHAPE_2KX1   = 2'h3
  } shape_t;

  // use of the block
  typedef enum logic [1:0] {
    USE_RAM  = 2'h0,
    USE_ROM  = 2'h1,
    USE_DUAL = 2'h2,
    USE_FIFO = 2'h3
  } use_t;

  // per-path register selects and source selects
  typedef struct packed {
    logic data_reg;
    logic addr_reg;
    logic out_reg;
    logic we_global;
    logic in_clk_alt;
    logic out_clk_alt;
  } cfg_t;

  // write-side request bundle from user logic
  typedef struct packed {
    logic [MAX_ADDR_W-1:0] addr;
    logic [MAX_DATA_W-1:0] data;
    logic                  we_local;
  } req_t;
endpackage

/* File: ram_core.sv */
// storage array of the embedded ram block with shape-aware access
`timescale 1ns/1ps
module ram_core #(
  parameter int BITS = 2048
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  // shape
  input  wire ram_block_pkg::shape_t  shape,
  // write strobe and address, generated by the top
  input  wire logic                   wr_pulse,
  input  wire logic [10:0]            addr,
  input  wire logic [7:0]             wdata,
  // combinational read of the addressed word
  output logic [7:0]                  rdata
);
  import ram_block_pkg::*;

  // all storage bits of the block (see R1); configuration leaves an all-zero pattern,
  // so reads before the first write are defined
  logic [BITS-1:0] mem = '0;
  logic [BITS-1:0] next_mem;

  // bit offset of a word given its shape; widths are 8,4,2,1
  function automatic logic [10:0] word_base(input shape_t s, input logic [10:0] a);
    case (s)
      SHAPE_256X8: word_base = {a[7:0], 3'h0};
      SHAPE_512X4: word_base = {a[8:0], 2'h0};
      SHAPE_1KX2:  word_base = {a[9:0], 1'h0};
      default:     word_base = a;
    endcase
  endfunction

  function automatic logic [7:0] width_mask(input shape_t s);
    case (s)
      SHAPE_256X8: width_mask = 8'hff;
      SHAPE_512X4: width_mask = 8'h0f;
      SHAPE_1KX2:  width_mask = 8'h03;
      default:     width_mask = 8'h01;
    endcase
  endfunction

  logic [10:0] base;
  logic [7:0]  mask;
  assign base = word_base(shape, addr);
  assign mask = width_mask(shape);

  // read is a pure function of address and contents (see R9)
  always_comb begin
    rdata = 8'h00;
    for (int i = 0; i < MAX_DATA_W; i++) begin
      if (mask[i]) begin
        rdata[i] = mem[11'(base + 11'(i))];
      end
    end
  end

  // only a write pulse changes contents (see R10)
  always_comb begin
    next_mem = mem;
    if (wr_pulse) begin
      for (int i = 0; i < MAX_DATA_W; i++) begin
        if (mask[i]) begin
          next_mem[11'(base + 11'(i))] = wdata[i];
        end
      end
    end
  end

  // contents survive reset: they model configuration-loaded bits
  always_ff @(posedge ref_clk) begin
    mem <= next_mem;
  end
endmodule

/* File: embedded_ram_block.sv */
// top of the embedded ram block: path registers, write strobe, read-only mode
`timescale 1ns/1ps
// Summary of operation
// R1 - 2048 storage bits, RAM/ROM/dual/FIFO uses; here only ROM differs, dual and FIFO act as RAM
// R2 - four shapes; address width follows depth
// R3 - data, address/we, output registers independently selectable
// R4 - input and output registers on separate clocks; here all registers run on ref_clk with phase qualifiers
// R5 - write pulse generated internally from clock
// R6 - wider words: blocks side by side, user
// R7 - depth cascading by upper address bits
// R8 - write request global or local; clock source select
// R9 - lookup contents fixed, read as function
// R10 - no write request leaves contents unchanged
module embedded_ram_block #(
  parameter int BITS = ram_block_pkg::TOTAL_BITS
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  // configuration
  input  wire ram_block_pkg::shape_t  shape,
  input  wire ram_block_pkg::use_t    block_use,
  input  wire ram_block_pkg::cfg_t    cfg,
  // clock-enable-free sampling phases for the two clock selections
  input  wire logic                   in_clk_phase,
  input  wire logic                   out_clk_phase,
  // user-side request
  input  wire ram_block_pkg::req_t    req,
  input  wire logic                   we_global_sig,
  // read result
  output logic [7:0]                  q,
  output logic                        wrote
);
  import ram_block_pkg::*;

  // registered input path (see R3)
  logic [10:0] addr_q;
  logic [7:0]  data_q;
  logic        we_q;
  logic [7:0]  q_r;
  logic        wrote_r;
  logic [10:0] next_addr_q;
  logic [7:0]  next_data_q;
  logic        next_we_q;
  logic [7:0]  next_q;
  logic        next_wrote;

  logic        we_src;
  logic [10:0] addr_eff;
  logic [7:0]  data_eff;
  logic        we_eff;
  logic        wr_pulse;
  logic [7:0]  rdata;
  logic        in_take;
  logic        out_take;

  // address bits above the shape's depth are ignored (see R2)
  // cascading in depth decodes those upper bits outside the block (see R7)
  function automatic logic [10:0] addr_mask(input shape_t s);
    case (s)
      SHAPE_256X8: addr_mask = 11'h0ff;
      SHAPE_512X4: addr_mask = 11'h1ff;
      SHAPE_1KX2:  addr_mask = 11'h3ff;
      default:     addr_mask = 11'h7ff;
    endcase
  endfunction

  // valid data bits of a word in each shape; the bits above read as zero
  function automatic logic [7:0] data_mask(input shape_t s);
    case (s)
      SHAPE_256X8: data_mask = 8'hff;
      SHAPE_512X4: data_mask = 8'h0f;
      SHAPE_1KX2:  data_mask = 8'h03;
      default:     data_mask = 8'h01;
    endcase
  endfunction

  // write request source select (see R8)
  assign we_src = cfg.we_global ? we_global_sig : req.we_local;

  // two clock selections modelled as phase qualifiers on ref_clk (see R4, R8)
  assign in_take  = cfg.in_clk_alt ? in_clk_phase : 1'b1;
  assign out_take = cfg.out_clk_alt ? out_clk_phase : 1'b1;

  always_comb begin
    next_addr_q = in_take ? req.addr : addr_q;
    next_data_q = in_take ? req.data : data_q;
    next_we_q   = in_take ? we_src : 1'b0;
  end

  // path selection, each independent (see R3)
  assign addr_eff = (cfg.addr_reg ? addr_q : req.addr) & addr_mask(shape);
  assign data_eff = cfg.data_reg ? data_q : req.data;
  assign we_eff   = cfg.addr_reg ? we_q : (we_src & in_take);

  // strobe: writes at each ref_clk edge while the write request stands; read-only use never writes (see R5, R9)
  assign wr_pulse = we_eff && (block_use != USE_ROM);

  ram_core #(
    .BITS (BITS)
  ) ram_core_i (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .shape    (shape),
    .wr_pulse (wr_pulse),
    .addr     (addr_eff),
    .wdata    (data_eff),
    .rdata    (rdata)
  );

  // output register or pass-through; outputs always leave a flip-flop,
  // so the unregistered choice still shows the word one edge later (see R3, R10)
  always_comb begin
    next_q = q_r;
    if (!cfg.out_reg || out_take) begin
      next_q = rdata;
    end
    next_wrote = wr_pulse;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      addr_q  <= RESET_ADDR;
      data_q  <= RESET_DATA;
      we_q    <= 1'b0;
      q_r     <= RESET_DATA;
      wrote_r <= 1'b0;
    end else begin
      addr_q  <= next_addr_q;
      data_q  <= next_data_q;
      we_q    <= next_we_q;
      q_r     <= next_q;
      wrote_r <= next_wrote;
    end
  end

  assign q     = q_r;
  assign wrote = wrote_r;

  // a strobe only when enabled and not read-only
  chk_rom_no_write: assert property (@(posedge ref_clk) disable iff (!rstn) // see R9
    (block_use == USE_ROM) |-> !wr_pulse)
    else $error("write strobe in read-only use");

  // read-only contents never move while the address stands
  chk_rom_holds: assert property (@(posedge ref_clk) disable iff (!rstn) // see R9
    ((block_use == USE_ROM) ##1 ($stable(addr_eff) && $stable(shape))) |-> $stable(rdata))
    else $error("read-only contents changed");

  // the flag is the only trace of a write that the user logic sees
  chk_wrote_follows: assert property (@(posedge ref_clk) disable iff (!rstn) // see R5
    wr_pulse |=> wrote)
    else $error("write not reported next cycle");

  chk_wrote_cause: assert property (@(posedge ref_clk) disable iff (!rstn) // see R5
    wrote |-> $past(wr_pulse))
    else $error("write reported without a strobe");

  // the written word reads back at the next edge if the address stands
  chk_write_lands: assert property (@(posedge ref_clk) disable iff (!rstn) // see R5
    (wr_pulse ##1 ($stable(addr_eff) && $stable(shape)))
      |-> (rdata == ($past(data_eff) & data_mask(shape))))
    else $error("written word not read back");

  // no request with the request path unregistered, no strobe; no strobe, no change of contents
  chk_idle_no_write: assert property (@(posedge ref_clk) disable iff (!rstn) // see R10
    (!we_src && !cfg.addr_reg) |-> !wr_pulse)
    else $error("write without request");

  chk_no_write_holds: assert property (@(posedge ref_clk) disable iff (!rstn) // see R10
    (!wr_pulse ##1 ($stable(addr_eff) && $stable(shape))) |-> $stable(rdata))
    else $error("contents changed without a write");

  // registered request path adds exactly one edge
  chk_reg_we_delay: assert property (@(posedge ref_clk) disable iff (!rstn) // see R3
    (cfg.addr_reg && $past(cfg.addr_reg) && block_use != USE_ROM && $past(in_take))
      |-> (wr_pulse == $past(we_src)))
    else $error("registered write request not one cycle late");

  chk_in_regs_load: assert property (@(posedge ref_clk) disable iff (!rstn) // see R3
    in_take |=> ((addr_q == $past(req.addr)) && (data_q == $past(req.data))))
    else $error("input registers missed a load");

  // address and data input registers freeze, and the write request register clears, while their own clock is idle
  chk_in_hold: assert property (@(posedge ref_clk) disable iff (!rstn) // see R4
    (cfg.in_clk_alt && !in_clk_phase) |=> ($stable(addr_q) && $stable(data_q) && !we_q))
    else $error("input registers moved off their clock");

  // output side: pass-through, registered, or held off its clock
  chk_out_follows: assert property (@(posedge ref_clk) disable iff (!rstn) // see R3
    !cfg.out_reg |=> (q == $past(rdata)))
    else $error("output does not follow read data");

  chk_out_reg_load: assert property (@(posedge ref_clk) disable iff (!rstn) // see R3
    (cfg.out_reg && (!cfg.out_clk_alt || out_clk_phase)) |=> (q == $past(rdata)))
    else $error("output register missed a load");

  chk_out_hold: assert property (@(posedge ref_clk) disable iff (!rstn) // see R4
    (cfg.out_reg && cfg.out_clk_alt && !out_clk_phase) |=> $stable(q))
    else $error("output register moved off its clock");

  // shape limits on address and word width
  chk_addr_range: assert property (@(posedge ref_clk) disable iff (!rstn) // see R2
    (shape == SHAPE_256X8) |-> (addr_eff[10:8] == 3'h0))
    else $error("address beyond depth");

  chk_narrow_zero: assert property (@(posedge ref_clk) disable iff (!rstn) // see R2
    (rdata & ~data_mask(shape)) == 8'h00)
    else $error("bits above the word width not zero");

  // write request taken from the selected source only
  chk_we_source: assert property (@(posedge ref_clk) disable iff (!rstn) // see R8
    (cfg.we_global && !cfg.addr_reg && block_use != USE_ROM)
      |-> (wr_pulse == (we_global_sig & in_take)))
    else $error("write source select wrong");

  chk_we_local: assert property (@(posedge ref_clk) disable iff (!rstn) // see R8
    (!cfg.we_global && !cfg.addr_reg && block_use != USE_ROM)
      |-> (wr_pulse == (req.we_local & in_take)))
    else $error("local write request not used");
endmodule

/* File: user_logic_model.sv */
// user logic model that presents address, data and write requests to the ram block
`timescale 1ns/1ps
module user_logic_model (
  // clock
  input  wire logic           ref_clk,
  // request side
  output ram_block_pkg::req_t req,
  output logic                we_global_sig
);
  import ram_block_pkg::*;

  initial begin
    req = '0;
    we_global_sig = 1'b0;
  end

  // hold everything for n edges, then drop the request; released data goes to its inverse
  // so a stale word can never pass for a fresh one
  task automatic drive(input logic [10:0] a, input logic [7:0] d, input logic loc,
                       input logic glob, input int n);
    @(negedge ref_clk);
    req.addr <= a; // one address shared by side-by-side blocks
    req.data <= (loc | glob) ? d : ~req.data;
    req.we_local <= loc;
    we_global_sig <= glob;
    repeat (n) @(negedge ref_clk);
    req.we_local <= 1'b0;
    we_global_sig <= 1'b0;
    req.data <= ~req.data;
  endtask
endmodule

/* File: embedded_ram_block_bench.sv */
// self-checking bench for the embedded ram block
`timescale 1ns/1ps
module embedded_ram_block_bench;
  import ram_block_pkg::*;
  logic       ref_clk   = 1'b0;
  logic       rstn      = 1'b0;
  shape_t     shape     = SHAPE_256X8;
  use_t       block_use = USE_RAM;
  cfg_t       cfg       = '0;
  req_t       req;
  logic       we_global_sig;
  logic [7:0] q;
  logic       wrote;
  logic       in_clk_phase  = 1'b1;
  logic       out_clk_phase = 1'b1;
  int         errors      = 0;
  int         check_count = 0;
  int         lat         = 2;

  always #5 ref_clk = ~ref_clk;

  embedded_ram_block embedded_ram_block_i (
    .ref_clk(ref_clk), .rstn(rstn), .shape(shape), .block_use(block_use), .cfg(cfg),
    .in_clk_phase(in_clk_phase), .out_clk_phase(out_clk_phase), .req(req),
    .we_global_sig(we_global_sig), .q(q), .wrote(wrote));
  user_logic_model user_logic_model_i (.ref_clk(ref_clk), .req(req),
    .we_global_sig(we_global_sig));

  task automatic check_q(input logic [7:0] exp);
    check_count++;
    if (q !== exp) begin
      errors++;
      $display("unexpected at %0t: q %h, expected %h", $time, q, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: write flag %b, expected %b", $time, got, exp);
    end
  endtask

  // the flag is collected over a short window because the registered request adds an edge
  task automatic write(input logic [10:0] a, input logic [7:0] d, input logic glob,
                       input logic exp);
    logic seen;
    user_logic_model_i.drive(a, d, !glob, glob, 1);
    seen = wrote;
    repeat (3) begin
      @(negedge ref_clk);
      seen = seen | wrote;
    end
    check_flag(seen, exp);
  endtask

  task automatic read(input logic [10:0] a, input logic [7:0] exp);
    user_logic_model_i.drive(a, 8'h00, 1'b0, 1'b0, lat);
    check_q(exp);
  endtask

  task automatic conclude;
    $display("errors %0d, checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    conclude();
  end

  initial begin
    logic [7:0] m;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check_q(8'h00);
    check_flag(wrote, 1'b0);
    rstn = 1'b1;
    write(11'h005, 8'haa, 1'b0, 1'b1);
    read(11'h005, 8'haa);
    write(11'h006, 8'h55, 1'b0, 1'b1);
    read(11'h005, 8'haa);
    read(11'h006, 8'h55);
    for (int s = 0; s < 4; s++) begin
      shape = shape_t'(s[1:0]);
      m = 8'hff >> (8 - (8 >> s));
      write(11'h003, 8'ha5, 1'b0, 1'b1);
      write(11'h004, 8'hff, 1'b0, 1'b1);
      read(11'h003, 8'ha5 & m);
      read(11'h003 + 11'(256 << s), 8'ha5 & m);
      read(11'h004, m);
    end
    shape = SHAPE_256X8;
    block_use = USE_ROM;
    write(11'h005, 8'h3c, 1'b0, 1'b0);
    read(11'h005, 8'haa);
    block_use = USE_RAM;
    cfg.we_global = 1'b1;
    write(11'h007, 8'h81, 1'b1, 1'b1);
    read(11'h007, 8'h81);
    cfg = '0;
    cfg.data_reg = 1'b1;
    cfg.addr_reg = 1'b1;
    cfg.out_reg = 1'b1;
    lat = 4;
    write(11'h009, 8'h77, 1'b0, 1'b1);
    read(11'h009, 8'h77);
    read(11'h007, 8'h81);
    cfg.in_clk_alt = 1'b1;
    write(11'h00a, 8'h34, 1'b0, 1'b1);
    in_clk_phase = 1'b0;
    write(11'h00a, 8'h12, 1'b0, 1'b0);
    in_clk_phase = 1'b1;
    read(11'h00a, 8'h34);
    cfg.out_clk_alt = 1'b1;
    out_clk_phase = 1'b0;
    read(11'h009, 8'h34);
    out_clk_phase = 1'b1;
    read(11'h009, 8'h77);
    conclude();
  end
endmodule
